// ==== bench/drive_fault_detector_bench.sv ====
// Self-checking bench for the drive fault detector.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_detector_bench;
  localparam logic [11:0] FULL_MASK = 12'h7a3;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] cause = 12'h000;
  logic settled_n = 1'b0, wr_mode = 1'b0, rd_gate = 1'b0, ac_cur = 1'b0;
  logic mh_n = 1'b1, dc_cur = 1'b0, slow = 1'b0, retracted, full;
  logic [2:0] clr = 3'h0;
  logic ce = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0, reg_rd = 1'b0, irq;
  logic [7:0] reg_rdata, rd;
  logic il_n, na_n, rw_n, nac_n, mh_led_n, nd_n, d_n, any_n, lamp_n, dstat;
  logic unload, rdy_rst, servo_dis, spin_n, door;
  int n_errors = 0;
  int total_checks = 0;

  always #2 sys_clk = ~sys_clk;

  drive_fault_detector drive_fault_detector_i (
    .sys_clk(sys_clk), .rst(rst), .ce(ce),
    .board_unseated(cause[7]), .chamber_disconnected(cause[8]), .supply_low(cause[6:0]),
    .heatsink_hot(cause[9]), .spindle_fault(cause[10]), .spindle_board_absent(cause[11]),
    .heads_settled_n(settled_n), .write_mode(wr_mode), .read_gate_active(rd_gate),
    .alternating_write_current(ac_cur), .multi_head_select_n(mh_n),
    .dc_write_current(dc_cur), .heads_retracted(retracted),
    .power_on_start(clr[0]), .run_selected(clr[1]), .clear_status_command(clr[2]),
    .interlock_fault_indicator_n(il_n), .no_access_write_led_n(na_n),
    .read_write_conflict_led_n(rw_n), .no_ac_current_led_n(nac_n),
    .multi_head_led_n(mh_led_n), .nondestructive_fault_n(nd_n), .destructive_fault_n(d_n),
    .any_write_fault_n(any_n), .drive_fault_lamp_n(lamp_n), .drive_fault_status(dstat),
    .head_unload_cmd(unload), .drive_ready_reset(rdy_rst), .servo_disable(servo_dis),
    .spindle_stop_n(spin_n), .door_unlock(door), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq)
  );

  drive_mech_model drive_mech_model_i (
    .sys_clk(sys_clk), .rst(rst), .head_unload_cmd(unload), .slow(slow),
    .heads_retracted(retracted)
  );

  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask

  task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_read(input logic [3:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic clear(input int k);
    if (k == 3) begin
      reg_write(fault_detect_pkg::REG_CONTROL, 8'h01);
    end else begin
      @(posedge sys_clk);
      clr[k] <= 1'b1;
      @(posedge sys_clk);
      clr <= 3'h0;
    end
    step(2);
  endtask

  task automatic idle();
    @(posedge sys_clk);
    cause <= 12'h000;
    settled_n <= 1'b0;
    wr_mode <= 1'b0;
    rd_gate <= 1'b0;
    ac_cur <= 1'b0;
    mh_n <= 1'b1;
    dc_cur <= 1'b0;
    step(4);
  endtask

  task automatic results();
    if (n_errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    fork
      begin
        #20000;
        n_errors++;
        results();
      end
    join_none
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    step(1);
    chk1(il_n, 1'b1);
    chk1(lamp_n, 1'b1);
    chk1(spin_n, 1'b1);
    reg_write(4'h2, 8'hff);
    reg_read(4'h2, rd);
    chk8(rd, 8'h00);
    reg_read(fault_detect_pkg::REG_MASK, rd);
    chk8(rd, 8'h00);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      wr_mode <= 1'b1;
      ac_cur <= 1'b1;
      settled_n <= (k % 2 == 0);
      step(2);
      @(posedge sys_clk);
      rd_gate <= (k % 2 == 1);
      step(4);
      chk1(na_n, k % 2 == 1);
      chk1(rw_n, k % 2 == 0);
      chk1(nd_n, 1'b0);
      chk1(any_n, 1'b0);
      chk1(lamp_n, 1'b0);
      chk1(dstat, 1'b1);
      chk1(d_n, 1'b1);
      chk1(unload, 1'b0);
      reg_read(fault_detect_pkg::REG_FAULT, rd);
      chk8(rd & 8'h1f, (k % 2 == 0) ? 8'h11 : 8'h12);
      if (k == 0) begin
        chk1(irq, 1'b0);
        reg_write(fault_detect_pkg::REG_MASK, 8'h02);
        step(2);
        chk1(irq, 1'b1);
        reg_read(fault_detect_pkg::REG_EVENT, rd);
        chk8(rd, 8'h02);
        step(2);
        chk1(irq, 1'b0);
        // A frozen block must ignore even a power-on clear.
        @(posedge sys_clk);
        ce <= 1'b0;
        clr[0] <= 1'b1;
        @(posedge sys_clk);
        clr <= 3'h0;
        step(2);
        chk1(na_n, 1'b0);
        @(posedge sys_clk);
        ce <= 1'b1;
      end
      @(posedge sys_clk);
      mh_n <= 1'b0;
      step(4);
      chk1(mh_led_n, 1'b1);
      chk1(d_n, 1'b1);
      idle();
      clear(k);
      chk1(na_n, 1'b1);
      chk1(rw_n, 1'b1);
      chk1(any_n, 1'b1);
      chk1(lamp_n, 1'b1);
    end
    for (int h = 0; h < 3; h++) begin
      @(posedge sys_clk);
      wr_mode <= (h == 0);
      mh_n <= (h != 1);
      dc_cur <= (h == 2);
      step(4);
      chk1(nac_n, h == 1);
      chk1(mh_led_n, h == 0);
      chk1(d_n, 1'b0);
      chk1(any_n, 1'b0);
      chk1(nd_n, 1'b1);
      chk1(unload, 1'b1);
      chk1(rdy_rst, 1'b1);
      chk1(servo_dis, 1'b1);
      chk1(dstat, 1'b1);
      chk1(lamp_n, 1'b0);
      reg_read(fault_detect_pkg::REG_FAULT, rd);
      chk8(rd & 8'h0f, (h == 0) ? 8'h04 : (h == 1) ? 8'h08 : 8'h0c);
      step(30);
      chk1(spin_n, 1'b1);
      chk1(door, 1'b0);
      if (h == 0) begin
        // An interlock arriving while the heads are parked still stops the spindle.
        @(posedge sys_clk);
        cause <= 12'h080;
        step(5);
        chk1(spin_n, 1'b0);
        chk1(door, 1'b1);
      end
      clear(2);
      chk1(d_n, 1'b0);
      idle();
      clear((h == 2) ? 1 : 0);
      chk1(d_n, 1'b1);
      chk1(nac_n, 1'b1);
      chk1(mh_led_n, 1'b1);
      chk1(unload, 1'b0);
    end
    reg_write(fault_detect_pkg::REG_MASK, 8'h01);
    reg_read(fault_detect_pkg::REG_EVENT, rd);
    for (int i = 0; i < 12; i++) begin
      full = FULL_MASK[i];
      @(posedge sys_clk);
      cause <= 12'h001 << i;
      slow <= i[0];
      step(5);
      chk1(il_n, 1'b0);
      chk1(unload, 1'b1);
      chk1(irq, 1'b1);
      reg_read(fault_detect_pkg::REG_EVENT, rd);
      chk8(rd & 8'h01, 8'h01);
      step(30);
      chk1(spin_n, !full);
      chk1(door, full);
      chk1(irq, 1'b0);
      idle();
      clear(0);
      chk1(il_n, 1'b1);
      chk1(spin_n, 1'b1);
      chk1(unload, 1'b0);
    end
    results();
  end
endmodule
`default_nettype wire

// ==== bench/drive_mech_model.sv ====
// Behavioural head carriage that retracts some time after an unload command.
`timescale 1ns/1ps
`default_nettype none
module drive_mech_model (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Unload command and speed choice
  input wire logic head_unload_cmd,
  input wire logic slow,
  // Carriage position
  output logic heads_retracted
);
  logic [4:0] cnt_ff;
  logic retracted_ff;

  // The carriage leaves the stop as soon as the command drops, so a stale
  // retraction flag can never satisfy a later unload by accident.
  // wait for retraction
  always_ff @(posedge sys_clk) begin
    if (rst || !head_unload_cmd) begin
      cnt_ff <= 5'h00;
      retracted_ff <= 1'b0;
    end else if (cnt_ff == (slow ? 5'h14 : 5'h02)) begin
      retracted_ff <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  assign heads_retracted = retracted_ff;
endmodule
`default_nettype wire

// ==== rtl/drive_fault_detector.sv ====
// Interlock and read/write fault detection with the head-unload sequence.
//
// Notes on behaviour
// R1 - An interlock fault is any unseated board, open chamber, low supply, hot sink, spindle fault or absent spindle board.
// R2 - An interlock fault lights the interlock indicator and runs unload, brake and door unlock.
// R3 - A missing -12, +5, +12, 25 Vac supply or absent spindle board only unloads the heads.
// R4 - Four read/write faults exist, two non-destructive and two destructive.
// R5 - Writing while the heads are not settled latches the no-access fault if none is latched.
// R6 - Read gate rising during write latches the conflict fault if none is latched.
// R7 - A non-destructive fault drives its LED, both summaries, the lamp and status bit 4.
// R8 - Non-destructive latches clear on power-on, run or a clear-status command.
// R9 - Write mode without alternating current latches the no-AC fault if none is latched.
// R10 - A low multi-head select latches the multi-head fault if none is latched.
// R11 - Write current outside write mode latches both the no-AC and multi-head faults.
// R12 - A destructive fault drives both summaries, locks out others and unloads the heads only.
// R13 - Destructive latches clear only on power-on or run, never on clear-status.
// R14 - Unload lights the lamp, sets bit 4, retracts, drops ready and servo; braking follows retraction.
// R15 - Inputs are synchronised and only one read/write fault, or the R11 pair, can latch per cycle.
`timescale 1ns/1ps
`default_nettype none
module drive_fault_detector (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Interlock chain and monitors (asynchronous)
  input wire logic board_unseated,
  input wire logic chamber_disconnected,
  input wire logic [fault_detect_pkg::SUPPLY_W-1:0] supply_low,
  input wire logic heatsink_hot,
  input wire logic spindle_fault,
  input wire logic spindle_board_absent,
  // Read/write monitors (asynchronous)
  input wire logic heads_settled_n,
  input wire logic write_mode,
  input wire logic read_gate_active,
  input wire logic alternating_write_current,
  input wire logic multi_head_select_n,
  input wire logic dc_write_current,
  input wire logic heads_retracted,
  // Clear sources (same clock)
  input wire logic power_on_start,
  input wire logic run_selected,
  input wire logic clear_status_command,
  // Fault indicators
  output logic interlock_fault_indicator_n,
  output logic no_access_write_led_n,
  output logic read_write_conflict_led_n,
  output logic no_ac_current_led_n,
  output logic multi_head_led_n,
  output logic nondestructive_fault_n,
  output logic destructive_fault_n,
  output logic any_write_fault_n,
  output logic drive_fault_lamp_n,
  output logic drive_fault_status,
  // Fault sequence commands
  output logic head_unload_cmd,
  output logic drive_ready_reset,
  output logic servo_disable,
  output logic spindle_stop_n,
  output logic door_unlock,
  // Register port
  input wire logic [fault_detect_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [fault_detect_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [fault_detect_pkg::DATA_W-1:0] reg_rdata,
  output logic irq
);
  logic [fault_detect_pkg::SYNC_W-1:0] sync_s;
  logic [fault_detect_pkg::SUPPLY_W-1:0] supply_s;
  logic settled_n_s, write_s, rgate_s, acw_s, mhs_n_s, dcw_s, retracted_s;
  logic rgate_prev_ff;
  logic interlock_fault_state, interlock_full_c, ilf_ff, full_req_ff;
  logic no_access_ff, rw_conflict_ff, no_ac_ff, multi_head_ff;
  logic soft_clear_pulse, hard_clear_pulse, ctl_clear;
  logic none_latched, set_dc, set_mh, set_ac, set_rw, set_ar;
  logic soft_any, hard_any;
  fault_detect_pkg::seq_state_t state_ff, nxt_state;
  logic [fault_detect_pkg::EV_W-1:0] event_ff, mask_ff, ev_c, ev_rd_clr;
  logic [fault_detect_pkg::DATA_W-1:0] rdata_ff;

  // R15 input sync
  fault_input_sync fault_input_sync_i (
    .sys_clk(sys_clk),
    .rst(rst),
    .ce(ce),
    .async_in({supply_low, heads_retracted, dc_write_current, multi_head_select_n,
               alternating_write_current, read_gate_active, write_mode, heads_settled_n,
               spindle_board_absent, spindle_fault, heatsink_hot, chamber_disconnected,
               board_unseated}),
    .sync_out(sync_s)
  );

  assign supply_s = sync_s[fault_detect_pkg::IDX_SUPPLY_LO +: fault_detect_pkg::SUPPLY_W];
  assign settled_n_s = sync_s[fault_detect_pkg::IDX_SETTLED_N];
  assign write_s = sync_s[fault_detect_pkg::IDX_WRITE];
  assign rgate_s = sync_s[fault_detect_pkg::IDX_READ_GATE];
  assign acw_s = sync_s[fault_detect_pkg::IDX_AC_CURRENT];
  assign mhs_n_s = sync_s[fault_detect_pkg::IDX_MULTI_HEAD_N];
  assign dcw_s = sync_s[fault_detect_pkg::IDX_DC_CURRENT];
  assign retracted_s = sync_s[fault_detect_pkg::IDX_RETRACTED];

  // R1 interlock chain
  assign interlock_fault_state = sync_s[fault_detect_pkg::IDX_BOARD_OUT]
    | sync_s[fault_detect_pkg::IDX_CHAMBER_OFF] | (|supply_s)
    | sync_s[fault_detect_pkg::IDX_HEAT_HOT] | sync_s[fault_detect_pkg::IDX_SPINDLE_FAULT]
    | sync_s[fault_detect_pkg::IDX_SPINDLE_BOARD_OUT];
  // R3 unload-only causes
  assign interlock_full_c = interlock_fault_state
    & ~(|(supply_s & fault_detect_pkg::SUPPLY_MINOR_MASK))
    & ~sync_s[fault_detect_pkg::IDX_SPINDLE_BOARD_OUT];

  // R8 clear sources
  assign ctl_clear = reg_wr && reg_addr == fault_detect_pkg::REG_CONTROL
    && reg_wdata[fault_detect_pkg::CTL_CLEAR_STATUS];
  assign hard_clear_pulse = power_on_start | run_selected;
  assign soft_clear_pulse = hard_clear_pulse | clear_status_command | ctl_clear;

  // R15 priority lockout
  assign none_latched = ~(no_access_ff | rw_conflict_ff | no_ac_ff | multi_head_ff);
  // R11 write current outside write
  assign set_dc = none_latched & dcw_s & ~write_s;
  // R10 multi head
  assign set_mh = none_latched & ~mhs_n_s & ~set_dc;
  // R9 no alternating current
  assign set_ac = none_latched & write_s & ~acw_s & ~set_dc & ~set_mh;
  // R6 read during write
  assign set_rw = none_latched & write_s & rgate_s & ~rgate_prev_ff & ~set_dc & ~set_mh
    & ~set_ac;
  // R5 write without access ready
  assign set_ar = none_latched & write_s & settled_n_s & ~set_dc & ~set_mh & ~set_ac
    & ~set_rw;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rgate_prev_ff <= 1'b0;
      ilf_ff <= 1'b0;
    end else if (ce) begin
      rgate_prev_ff <= rgate_s;
      ilf_ff <= interlock_fault_state;
    end
  end

  // R4 four fault latches
  // R8 soft latches, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      no_access_ff <= 1'b0;
      rw_conflict_ff <= 1'b0;
    end else if (ce) begin
      no_access_ff <= set_ar | (no_access_ff & ~soft_clear_pulse);
      rw_conflict_ff <= set_rw | (rw_conflict_ff & ~soft_clear_pulse);
    end
  end

  // R13 hard latches, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      no_ac_ff <= 1'b0;
      multi_head_ff <= 1'b0;
    end else if (ce) begin
      no_ac_ff <= set_ac | set_dc | (no_ac_ff & ~hard_clear_pulse);
      multi_head_ff <= set_mh | set_dc | (multi_head_ff & ~hard_clear_pulse);
    end
  end

  assign soft_any = no_access_ff | rw_conflict_ff;
  assign hard_any = no_ac_ff | multi_head_ff;

  // R7 indicator outputs
  assign no_access_write_led_n = ~no_access_ff;
  assign read_write_conflict_led_n = ~rw_conflict_ff;
  assign no_ac_current_led_n = ~no_ac_ff;
  assign multi_head_led_n = ~multi_head_ff;
  assign nondestructive_fault_n = ~soft_any;
  assign destructive_fault_n = ~hard_any;
  assign any_write_fault_n = none_latched;
  // R2 interlock indicator
  assign interlock_fault_indicator_n = ~ilf_ff;
  // R14 lamp and bit 4
  assign drive_fault_status = soft_any | (state_ff != fault_detect_pkg::SEQ_IDLE);
  assign drive_fault_lamp_n = ~drive_fault_status;

  // The full-stop request outlives the interlock so a brief dip still stops the spindle.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      full_req_ff <= 1'b0;
    end else if (ce) begin
      full_req_ff <= interlock_full_c | (full_req_ff & ~(hard_clear_pulse & ~ilf_ff));
    end
  end
  // R12 unload then optional stop
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      fault_detect_pkg::SEQ_IDLE: begin
        if (ilf_ff || hard_any) begin
          nxt_state = fault_detect_pkg::SEQ_UNLOAD;
        end
      end
      fault_detect_pkg::SEQ_UNLOAD: begin
        if (retracted_s) begin
          nxt_state = full_req_ff ? fault_detect_pkg::SEQ_STOP : fault_detect_pkg::SEQ_HOLD;
        end
      end
      fault_detect_pkg::SEQ_HOLD: begin
        if (full_req_ff) begin
          nxt_state = fault_detect_pkg::SEQ_STOP;
        end
      end
      fault_detect_pkg::SEQ_STOP: nxt_state = fault_detect_pkg::SEQ_STOP;
      default: begin
        nxt_state = fault_detect_pkg::SEQ_IDLE;
      end
    endcase
    if (hard_clear_pulse && !ilf_ff) begin
      nxt_state = fault_detect_pkg::SEQ_IDLE;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_ff <= fault_detect_pkg::SEQ_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  // R14 sequence commands
  assign head_unload_cmd = state_ff != fault_detect_pkg::SEQ_IDLE;
  assign drive_ready_reset = state_ff != fault_detect_pkg::SEQ_IDLE;
  assign servo_disable = state_ff != fault_detect_pkg::SEQ_IDLE;
  // R3 brake and door after retraction
  assign spindle_stop_n = state_ff != fault_detect_pkg::SEQ_STOP;
  assign door_unlock = state_ff == fault_detect_pkg::SEQ_STOP;

  // Events for the interrupt status register.
  assign ev_c[fault_detect_pkg::EV_INTERLOCK] = interlock_fault_state & ~ilf_ff;
  assign ev_c[fault_detect_pkg::EV_SOFT_FAULT] = set_ar | set_rw;
  assign ev_c[fault_detect_pkg::EV_HARD_FAULT] = set_ac | set_mh | set_dc;
  assign ev_c[fault_detect_pkg::EV_RETRACTED] = (state_ff == fault_detect_pkg::SEQ_UNLOAD)
    & retracted_s;
  assign ev_rd_clr = (reg_rd && reg_addr == fault_detect_pkg::REG_EVENT) ? event_ff : '0;

  // A read clears only what it returned; a new event in that cycle survives.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      event_ff <= fault_detect_pkg::EV_RESET;
    end else if (ce) begin
      event_ff <= (event_ff & ~ev_rd_clr) | ev_c;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_ff <= fault_detect_pkg::MASK_RESET;
    end else if (ce && reg_wr && reg_addr == fault_detect_pkg::REG_MASK) begin
      mask_ff <= reg_wdata[fault_detect_pkg::EV_W-1:0];
    end
  end

  assign irq = |(event_ff & mask_ff);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (ce) begin
      rdata_ff <= '0;
      if (reg_rd && reg_addr == fault_detect_pkg::REG_EVENT) begin
        rdata_ff[fault_detect_pkg::EV_W-1:0] <= event_ff;
      end else if (reg_rd && reg_addr == fault_detect_pkg::REG_MASK) begin
        rdata_ff[fault_detect_pkg::EV_W-1:0] <= mask_ff;
      end else if (reg_rd && reg_addr == fault_detect_pkg::REG_FAULT) begin
        rdata_ff[fault_detect_pkg::FLD_NO_ACCESS] <= no_access_ff;
        rdata_ff[fault_detect_pkg::FLD_RW_CONFLICT] <= rw_conflict_ff;
        rdata_ff[fault_detect_pkg::FLD_NO_AC] <= no_ac_ff;
        rdata_ff[fault_detect_pkg::FLD_MULTI_HEAD] <= multi_head_ff;
        rdata_ff[fault_detect_pkg::FLD_DRIVE_FAULT] <= drive_fault_status;
        rdata_ff[fault_detect_pkg::FLD_INTERLOCK] <= ilf_ff;
        rdata_ff[fault_detect_pkg::FLD_FULL_STOP] <= full_req_ff;
      end
    end
  end
  assign reg_rdata = rdata_ff;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  sequence unload_cmds_s;
    head_unload_cmd && drive_ready_reset && servo_disable && spindle_stop_n;
  endsequence
  sequence full_stop_s;
    !spindle_stop_n && door_unlock && head_unload_cmd;
  endsequence
  AST_INTERLOCK_INDICATOR: assert property ( // R1
    ce && interlock_fault_state |=> !interlock_fault_indicator_n)
    else $error("interlock cause did not light the interlock indicator");
  AST_UNLOAD_ONLY: assert property ( // R3
    !full_req_ff |-> spindle_stop_n && !door_unlock)
    else $error("spindle braked without a full-stop interlock");
  AST_NO_ACCESS_WRITE: assert property ( // R5
    ce && any_write_fault_n && write_s && settled_n_s |=> !any_write_fault_n)
    else $error("write without settled heads latched no fault");
  AST_READ_WRITE: assert property ( // R6
    ce && any_write_fault_n && write_s && rgate_s && !rgate_prev_ff |=> !any_write_fault_n)
    else $error("read gate during write latched no fault");
  AST_SOFT_OUTPUTS: assert property ( // R7
    !nondestructive_fault_n |-> !any_write_fault_n && !drive_fault_lamp_n && drive_fault_status)
    else $error("non-destructive fault without summary, lamp or status bit");
  AST_SOFT_CLEAR: assert property ( // R8
    ce && soft_clear_pulse && !write_s |=> nondestructive_fault_n)
    else $error("clear left a non-destructive latch set");
  AST_DC_BOTH: assert property ( // R11
    ce && any_write_fault_n && dcw_s && !write_s |=> !no_ac_current_led_n && !multi_head_led_n)
    else $error("write current outside write did not set both latches");
  AST_HARD_HOLD: assert property ( // R13
    ce && !destructive_fault_n && clear_status_command && !hard_clear_pulse
    |=> !destructive_fault_n)
    else $error("clear-status command cleared a destructive latch");
  AST_ONE_PER_CYCLE: assert property ( // R15
    $fell(any_write_fault_n) |-> $countones({no_access_ff, rw_conflict_ff, no_ac_ff}) == 1
      || (multi_head_ff && !no_access_ff && !rw_conflict_ff))
    else $error("more than one read/write fault latched at once");
  AST_HARD_UNLOAD: assert property ( // R12
    ce && !destructive_fault_n && !ilf_ff && state_ff == fault_detect_pkg::SEQ_IDLE
    && !hard_clear_pulse |=> unload_cmds_s)
    else $error("destructive fault did not start a head unload");
  AST_STOP_AFTER_RETRACT: assert property ( // R14
    ce && state_ff == fault_detect_pkg::SEQ_UNLOAD && retracted_s && full_req_ff
    && !(hard_clear_pulse && !ilf_ff) |=> full_stop_s)
    else $error("full stop did not follow retraction");
endmodule
`default_nettype wire

// ==== rtl/fault_input_sync.sv ====
// Two-stage synchroniser for all asynchronous fault inputs.
`timescale 1ns/1ps
`default_nettype none
module fault_input_sync (
  // Clock, reset and enable
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ce,
  // Raw and synchronised inputs
  input wire logic [fault_detect_pkg::SYNC_W-1:0] async_in,
  output logic [fault_detect_pkg::SYNC_W-1:0] sync_out
);
  logic [fault_detect_pkg::SYNC_W-1:0] meta_ff;

  // The first stage feeds only the second stage.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_ff <= fault_detect_pkg::SYNC_INIT;
      sync_out <= fault_detect_pkg::SYNC_INIT;
    end else if (ce) begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule
`default_nettype wire

// ==== shared/fault_detect_pkg.sv ====
// Constants shared by the drive fault detector and its input synchroniser.
package fault_detect_pkg;
  // Synchronised input vector layout.
  localparam int IDX_BOARD_OUT = 0;
  localparam int IDX_CHAMBER_OFF = 1;
  localparam int IDX_HEAT_HOT = 2;
  localparam int IDX_SPINDLE_FAULT = 3;
  localparam int IDX_SPINDLE_BOARD_OUT = 4;
  localparam int IDX_SETTLED_N = 5;
  localparam int IDX_WRITE = 6;
  localparam int IDX_READ_GATE = 7;
  localparam int IDX_AC_CURRENT = 8;
  localparam int IDX_MULTI_HEAD_N = 9;
  localparam int IDX_DC_CURRENT = 10;
  localparam int IDX_RETRACTED = 11;
  localparam int IDX_SUPPLY_LO = 12;
  localparam int SUPPLY_W = 7;
  localparam int SYNC_W = 19;
  // Supply bits: -36, -24, -12, +5, +12, +36 Vdc, 25 Vac.
  // Losing -12, +5, +12 or 25 Vac leaves no power to brake or unlock.
  localparam logic [SUPPLY_W-1:0] SUPPLY_MINOR_MASK = 7'h5c;
  // Active-low inputs idle high, so they leave reset inactive.
  localparam logic [SYNC_W-1:0] SYNC_INIT = 19'h00220;

  // Register bus.
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [ADDR_W-1:0] REG_EVENT = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MASK = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FAULT = 4'h8;
  localparam logic [ADDR_W-1:0] REG_CONTROL = 4'hc;

  // Event status and mask bits.
  localparam int EV_W = 4;
  localparam int EV_INTERLOCK = 0;
  localparam int EV_SOFT_FAULT = 1;
  localparam int EV_HARD_FAULT = 2;
  localparam int EV_RETRACTED = 3;
  localparam logic [EV_W-1:0] EV_RESET = 4'h0;
  localparam logic [EV_W-1:0] MASK_RESET = 4'h0;

  // Fault register fields; the drive fault flag sits at status bit 4.
  localparam int FLD_NO_ACCESS = 0;
  localparam int FLD_RW_CONFLICT = 1;
  localparam int FLD_NO_AC = 2;
  localparam int FLD_MULTI_HEAD = 3;
  localparam int FLD_DRIVE_FAULT = 4;
  localparam int FLD_INTERLOCK = 5;
  localparam int FLD_FULL_STOP = 6;
  localparam int CTL_CLEAR_STATUS = 0;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_UNLOAD = 2'b01,
    SEQ_HOLD = 2'b10,
    SEQ_STOP = 2'b11
  } seq_state_t;
endpackage
